/* File: rtl/abm_pkg.sv */
// shared constants, types and helper functions of the message block mapper
// ----------
// Contract
// - terminal sends each command unchanged in blocks
// - data only with 61,62,63,9X status words
// - terminal passes received fields on unmodified
// - response is one field or chained fields
// - long commands split over chained blocks
// - four cases by command/response data presence
// - exactly one response per command message
// - card may turn 9000 into 91XX
// - fetch INS 12 answered with data, 9000
// - terminal response INS 14 carries command data
// - envelope is case 4, INS C2, Le 00
// - envelope 9000 data goes to positive ack
// - envelope 62XX/63XX data goes to error ack
// - card answers 9300 when toolkit busy (card end does this for envelope INS C2 only)
// ----------
package abm_pkg;

  // ----------
  // sizes and byte positions
  // ----------
  localparam int         ABM_IFS_DEF   = 32;
  localparam int         ABM_CNT_W     = 16;
  localparam logic [7:0] ABM_CLA_DEF   = 8'h00;
  localparam logic [ABM_CNT_W-1:0] ABM_POS_INS   = 16'h0001;
  localparam logic [ABM_CNT_W-1:0] ABM_POS_LC    = 16'h0004;
  localparam logic [ABM_CNT_W-1:0] ABM_HDR_LEN   = 16'h0004;
  localparam logic [2:0]           ABM_FETCH_LAST = 3'h4;

  // ----------
  // instruction bytes and status words
  // ----------
  localparam logic [7:0]  ABM_INS_FETCH    = 8'h12;
  localparam logic [7:0]  ABM_INS_TERM_RSP = 8'h14;
  localparam logic [7:0]  ABM_INS_ENVELOPE = 8'hC2;
  localparam logic [7:0]  ABM_ENV_LE       = 8'h00;
  localparam logic [7:0]  ABM_P_ZERO       = 8'h00;
  localparam logic [15:0] ABM_SW_OK        = 16'h9000;
  localparam logic [15:0] ABM_SW_TK_BUSY   = 16'h9300;
  localparam logic [7:0]  ABM_SW1_PRO      = 8'h91;
  localparam logic [7:0]  ABM_SW1_NORMAL   = 8'h61;
  localparam logic [7:0]  ABM_SW1_WARN_A   = 8'h62;
  localparam logic [7:0]  ABM_SW1_WARN_B   = 8'h63;
  localparam logic [3:0]  ABM_SW1_APP_NIB  = 4'h9;

  typedef enum logic [1:0] {
    ABM_CASE1 = 2'h0,
    ABM_CASE2 = 2'h1,
    ABM_CASE3 = 2'h2,
    ABM_CASE4 = 2'h3
  } abm_case_e;

  // ----------
  // helpers
  // ----------
  function automatic logic abm_sw_data_ok(input logic [7:0] sw1);
    abm_sw_data_ok = (sw1 == ABM_SW1_NORMAL) || (sw1 == ABM_SW1_WARN_A) ||
                     (sw1 == ABM_SW1_WARN_B) || (sw1[7:4] == ABM_SW1_APP_NIB);
  endfunction

  function automatic logic abm_sw_warn(input logic [7:0] sw1);
    abm_sw_warn = (sw1 == ABM_SW1_WARN_A) || (sw1 == ABM_SW1_WARN_B);
  endfunction

  // total is the command length in bytes, lc the byte after the header
  function automatic abm_case_e abm_case(input logic [ABM_CNT_W-1:0] total,
                                         input logic [7:0]           lc);
    if (total == ABM_HDR_LEN) begin
      abm_case = ABM_CASE1;
    end else if (total == ABM_HDR_LEN + 16'h0001) begin
      abm_case = ABM_CASE2;
    end else if (total == ABM_HDR_LEN + 16'h0001 + {8'h00, lc}) begin
      abm_case = ABM_CASE3;
    end else begin
      abm_case = ABM_CASE4;
    end
  endfunction

endpackage

/* File: rtl/abm_link_if.sv */
// block link between the terminal transport end and the card end
`timescale 1ns/1ps
interface abm_link_if;
  // terminal to card blocks
  logic [7:0] t2c_data;
  logic       t2c_valid;
  logic       t2c_ready;
  logic       t2c_end;
  logic       t2c_chain;
  // card to terminal blocks
  logic [7:0] c2t_data;
  logic       c2t_valid;
  logic       c2t_ready;
  logic       c2t_end;
  logic       c2t_chain;

  modport term (
    output t2c_data, t2c_valid, t2c_end, t2c_chain, c2t_ready,
    input  t2c_ready, c2t_data, c2t_valid, c2t_end, c2t_chain
  );
  modport card (
    input  t2c_data, t2c_valid, t2c_end, t2c_chain, c2t_ready,
    output t2c_ready, c2t_data, c2t_valid, c2t_end, c2t_chain
  );
endinterface

/* File: rtl/abm_seg.sv */
// cuts a byte message into blocks of at most ifs bytes, chaining all but the last
`timescale 1ns/1ps
module abm_seg
  import abm_pkg::*;
#(
  parameter int IFS = ABM_IFS_DEF
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // message side
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  input  wire logic       in_last,
  output logic            in_ready,
  // block side
  output logic [7:0]      out_data,
  output logic            out_valid,
  output logic            out_end,
  output logic            out_chain,
  input  wire logic       out_ready
);
  logic [7:0] data_r;
  logic       valid_r;
  logic       end_r;
  logic       chain_r;
  logic [ABM_CNT_W-1:0] cnt_r;

  wire take      = in_valid && in_ready;
  wire blk_full  = (cnt_r == ABM_CNT_W'(IFS - 1));

  // single output stage; ready follows the far side so no byte is dropped
  assign in_ready  = !valid_r || out_ready;
  assign out_data  = data_r;
  assign out_valid = valid_r;
  assign out_end   = end_r;
  assign out_chain = chain_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_r  <= 8'h00;
      valid_r <= 1'b0;
      end_r   <= 1'b0;
      chain_r <= 1'b0;
      cnt_r   <= '0;
    end else if (take) begin
      data_r  <= in_data;
      valid_r <= 1'b1;
      end_r   <= in_last || blk_full;
      chain_r <= !in_last && blk_full;
      cnt_r   <= (in_last || blk_full) ? '0 : cnt_r + 1'b1;
    end else if (out_ready) begin
      valid_r <= 1'b0;
    end
  end
endmodule

/* File: rtl/abm_card.sv */
// card end: takes command blocks, answers each command with one response
`timescale 1ns/1ps
module abm_card
  import abm_pkg::*;
#(
  parameter int IFS = ABM_IFS_DEF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // link
  abm_link_if.card         link,
  // command out to card logic
  output logic [7:0]       cmd_data,
  output logic             cmd_valid,
  output logic             cmd_last,
  output logic [7:0]       cmd_ins,
  // response in from card logic
  input  wire logic        rsp_go,
  input  wire logic [15:0] rsp_sw,
  input  wire logic        rsp_has_data,
  input  wire logic [7:0]  rsp_data,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_last,
  output logic             rsp_ready,
  // toolkit state
  input  wire logic        pro_pending,
  input  wire logic [7:0]  pro_len,
  input  wire logic        toolkit_busy
);
  typedef enum logic [4:0] {
    C_CMD  = 5'h01,
    C_WAIT = 5'h02,
    C_DATA = 5'h04,
    C_SW1  = 5'h08,
    C_SW2  = 5'h10
  } abm_cst_e;

  abm_cst_e   st_r;
  abm_cst_e   st_nxt;
  logic [7:0] data_r;
  logic       valid_r;
  logic       last_r;
  logic [7:0] ins_r;
  logic       rdy_r;
  logic [15:0] sw_r;
  logic [ABM_CNT_W-1:0] idx_r;

  wire rx      = link.t2c_valid && rdy_r;
  wire rx_last = rx && link.t2c_end && !link.t2c_chain;
  wire is_env_busy = (ins_r == ABM_INS_ENVELOPE) && toolkit_busy;
  wire [15:0] sw_a = (ins_r == ABM_INS_FETCH) ? ABM_SW_OK :
                     is_env_busy ? ABM_SW_TK_BUSY : rsp_sw;
  wire [15:0] sw_fin = (sw_a == ABM_SW_OK && pro_pending) ?
                       {ABM_SW1_PRO, pro_len} : sw_a;
  wire data_ok = rsp_has_data && !is_env_busy && abm_sw_data_ok(sw_fin[15:8]);

  logic [7:0] seg_data;
  logic       seg_valid;
  logic       seg_last;
  logic       seg_ready;

  assign seg_data  = (st_r == C_DATA) ? rsp_data :
                     (st_r == C_SW1) ? sw_r[15:8] : sw_r[7:0];
  assign seg_valid = (st_r == C_DATA) ? rsp_valid : (st_r == C_SW1) || (st_r == C_SW2);
  assign seg_last  = (st_r == C_SW2);
  // card logic must hold rsp_data until ready; it may not stall mid-block forever
  assign rsp_ready = (st_r == C_DATA) && seg_ready;
  assign cmd_data  = data_r;
  assign cmd_valid = valid_r;
  assign cmd_last  = last_r;
  assign cmd_ins   = ins_r;
  assign link.t2c_ready = rdy_r;

  abm_seg #(.IFS(IFS)) u_seg (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (seg_data),
    .in_valid  (seg_valid),
    .in_last   (seg_last),
    .in_ready  (seg_ready),
    .out_data  (link.c2t_data),
    .out_valid (link.c2t_valid),
    .out_end   (link.c2t_end),
    .out_chain (link.c2t_chain),
    .out_ready (link.c2t_ready)
  );

  // one response per command: no new command is taken until sw2 is queued
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      C_CMD:  if (rx_last) st_nxt = C_WAIT;
      C_WAIT: if (rsp_go) st_nxt = data_ok ? C_DATA : C_SW1;
      C_DATA: if (rsp_valid && seg_ready && rsp_last) st_nxt = C_SW1;
      C_SW1:  if (seg_ready) st_nxt = C_SW2;
      C_SW2:  if (seg_ready) st_nxt = C_CMD;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= C_CMD;
      data_r  <= 8'h00;
      valid_r <= 1'b0;
      last_r  <= 1'b0;
      ins_r   <= 8'h00;
      rdy_r   <= 1'b0;
      sw_r    <= 16'h0000;
      idx_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      rdy_r   <= (st_nxt == C_CMD) && !rx_last;
      valid_r <= rx;
      last_r  <= rx_last;
      if (rx) begin
        data_r <= link.t2c_data;
        idx_r  <= rx_last ? '0 : idx_r + 1'b1;
        if (idx_r == ABM_POS_INS) ins_r <= link.t2c_data;
      end
      if (st_r == C_WAIT && rsp_go) sw_r <= sw_fin;
    end
  end
endmodule

/* File: rtl/abm_term.sv */
// terminal transport end: sends command messages, collects and classifies responses
`timescale 1ns/1ps
module abm_term
  import abm_pkg::*;
#(
  parameter int         IFS       = ABM_IFS_DEF,
  parameter logic [7:0] FETCH_CLA = ABM_CLA_DEF
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // link
  abm_link_if.term        link,
  // command message from the application
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_last,
  output logic            cmd_ready,
  input  wire logic       fetch_go,
  // response message to the application
  output logic [7:0]      rsp_data,
  output logic            rsp_valid,
  output logic            rsp_last,
  output logic            rsp_done,
  output logic [15:0]     rsp_sw,
  output logic            rsp_bad,
  // exchange classification
  output logic [1:0]      xchg_case,
  output logic            cmd_err,
  output logic            busy,
  // toolkit events
  output logic            ack_pos,
  output logic            ack_neg,
  output logic            pro_pending,
  output logic [7:0]      pro_len,
  output logic            toolkit_busy
);
  // ----------
  // state
  // ----------
  typedef enum logic [3:0] {
    T_IDLE  = 4'h1,
    T_CMD   = 4'h2,
    T_FETCH = 4'h4,
    T_RSP   = 4'h8
  } abm_tst_e;

  abm_tst_e   st_r;
  abm_tst_e   st_nxt;
  logic [ABM_CNT_W-1:0] tx_cnt_r;
  logic [ABM_CNT_W-1:0] rx_cnt_r;
  logic [7:0] ins_r;
  logic [7:0] lc_r;
  logic [7:0] prev_r;
  logic [2:0] fidx_r;
  logic       rdy_r;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       rlast_r;
  logic       rdone_r;
  logic [15:0] sw_r;
  logic [15:0] rsw_r;
  logic       rbad_r;
  abm_case_e  case_r;
  logic       cerr_r;
  logic       apos_r;
  logic       aneg_r;
  logic       ppend_r;
  logic [7:0] plen_r;
  logic       tkb_r;

  // ----------
  // command path: user stream or built-in fetch, both through the segmenter
  // ----------
  logic [7:0] seg_data;
  logic       seg_valid;
  logic       seg_last;
  logic       seg_ready;
  logic [7:0] fetch_byte;

  wire in_cmd   = (st_r == T_CMD);
  wire in_fetch = (st_r == T_FETCH);

  // fetch header: class, ins 12, p1, p2, then le taken from the pending length
  assign fetch_byte = (fidx_r == 3'h0) ? FETCH_CLA :
                      (fidx_r == 3'h1) ? ABM_INS_FETCH :
                      (fidx_r == ABM_FETCH_LAST) ? plen_r : ABM_P_ZERO;
  // bytes pass untouched into the information field
  assign seg_data  = in_fetch ? fetch_byte : cmd_data;
  assign seg_valid = in_fetch || (in_cmd && cmd_valid);
  assign seg_last  = in_fetch ? (fidx_r == ABM_FETCH_LAST) : cmd_last;
  assign cmd_ready = in_cmd && seg_ready;

  wire tx      = seg_valid && seg_ready;
  wire tx_last = tx && seg_last;
  wire [ABM_CNT_W-1:0] tx_total = tx_cnt_r + 1'b1;
  wire [7:0] lc_now  = (tx_cnt_r == ABM_POS_LC) ? seg_data : lc_r;
  wire [7:0] ins_now = (tx_cnt_r == ABM_POS_INS) ? seg_data : ins_r;
  wire abm_case_e case_now = abm_case(tx_total, lc_now);

  // command checks on the last byte: terminal response needs data, envelope
  // must be case 4 ending in le 00
  wire err_now = ((ins_now == ABM_INS_TERM_RSP) &&
                  (case_now == ABM_CASE1 || case_now == ABM_CASE2)) ||
                 ((ins_now == ABM_INS_ENVELOPE) &&
                  (case_now != ABM_CASE4 || seg_data != ABM_ENV_LE));

  abm_seg #(.IFS(IFS)) u_seg (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (seg_data),
    .in_valid  (seg_valid),
    .in_last   (seg_last),
    .in_ready  (seg_ready),
    .out_data  (link.t2c_data),
    .out_valid (link.t2c_valid),
    .out_end   (link.t2c_end),
    .out_chain (link.t2c_chain),
    .out_ready (link.t2c_ready)
  );

  // ----------
  // response path
  // ----------
  wire rx      = link.c2t_valid && rdy_r;
  wire rx_last = rx && link.c2t_end && !link.c2t_chain;
  wire [15:0] sw_now = {prev_r, link.c2t_data};
  wire        is_env = (ins_r == ABM_INS_ENVELOPE);
  // data bytes are everything but the two trailing status bytes
  wire        has_data = (rx_cnt_r > 16'h0001);

  assign link.c2t_ready = rdy_r;

  // ----------
  // sequencing: the link is half duplex, one command then its one response
  // ----------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      T_IDLE: begin
        if (fetch_go) begin
          st_nxt = T_FETCH;
        end else if (cmd_valid) begin
          st_nxt = T_CMD;
        end
      end
      T_CMD:   if (tx_last) st_nxt = T_RSP;
      T_FETCH: if (tx_last) st_nxt = T_RSP;
      T_RSP:   if (rx_last) st_nxt = T_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= T_IDLE;
      tx_cnt_r <= '0;
      ins_r    <= 8'h00;
      lc_r     <= 8'h00;
      fidx_r   <= 3'h0;
      case_r   <= ABM_CASE1;
      cerr_r   <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (tx) begin
        tx_cnt_r <= tx_last ? '0 : tx_total;
        ins_r    <= ins_now;
        lc_r     <= lc_now;
        fidx_r   <= tx_last ? 3'h0 : fidx_r + 3'h1;
      end
      if (tx_last) begin
        case_r <= case_now;
        cerr_r <= err_now;
      end
    end
  end

  // received bytes go out exactly as they arrived, field after field
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r    <= 1'b0;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      rlast_r  <= 1'b0;
      prev_r   <= 8'h00;
      rx_cnt_r <= '0;
    end else begin
      rdy_r    <= (st_nxt == T_RSP) && !rx_last;
      rvalid_r <= rx;
      rlast_r  <= rx_last;
      if (rx) begin
        rdata_r  <= link.c2t_data;
        prev_r   <= link.c2t_data;
        rx_cnt_r <= rx_last ? '0 : rx_cnt_r + 1'b1;
      end
    end
  end

  // status word evaluation at the end of each response
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdone_r <= 1'b0;
      rsw_r   <= 16'h0000;
      rbad_r  <= 1'b0;
      apos_r  <= 1'b0;
      aneg_r  <= 1'b0;
      ppend_r <= 1'b0;
      plen_r  <= 8'h00;
      tkb_r   <= 1'b0;
    end else begin
      rdone_r <= rx_last;
      apos_r  <= rx_last && is_env && (sw_now == ABM_SW_OK);
      aneg_r  <= rx_last && is_env && abm_sw_warn(sw_now[15:8]);
      if (rx_last) begin
        rsw_r   <= sw_now;
        rbad_r  <= has_data && !abm_sw_data_ok(sw_now[15:8]);
        ppend_r <= (sw_now[15:8] == ABM_SW1_PRO);
        tkb_r   <= is_env && (sw_now == ABM_SW_TK_BUSY);
        if (sw_now[15:8] == ABM_SW1_PRO) begin
          plen_r <= sw_now[7:0];
        end
      end
    end
  end

  // ----------
  // outputs
  // ----------
  assign rsp_data     = rdata_r;
  assign rsp_valid    = rvalid_r;
  assign rsp_last     = rlast_r;
  assign rsp_done     = rdone_r;
  assign rsp_sw       = rsw_r;
  assign rsp_bad      = rbad_r;
  assign xchg_case    = case_r;
  assign cmd_err      = cerr_r;
  assign ack_pos      = apos_r;
  assign ack_neg      = aneg_r;
  assign pro_pending  = ppend_r;
  assign pro_len      = plen_r;
  assign toolkit_busy = tkb_r;
  // busy is low only while idle; a flop copy would lag the state by a cycle
  assign busy         = (st_r != T_IDLE);
endmodule

/* File: tb/abm_link_assertions.sv */
// concurrent checks on the block link between the two ends
`timescale 1ns/1ps
module abm_link_assertions
  import abm_pkg::*;
#(
  parameter int IFS = ABM_IFS_DEF
) (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // terminal to card
  input wire logic [7:0] t2c_data,
  input wire logic       t2c_valid,
  input wire logic       t2c_ready,
  input wire logic       t2c_end,
  input wire logic       t2c_chain,
  // card to terminal
  input wire logic [7:0] c2t_data,
  input wire logic       c2t_valid,
  input wire logic       c2t_ready,
  input wire logic       c2t_end,
  input wire logic       c2t_chain
);
  // ----------
  // helper state
  // ----------
  logic [15:0] blk_r;
  logic [15:0] msg_r;
  logic [15:0] rcnt_r;
  logic [7:0]  ins_r;
  logic [7:0]  prev_r;
  logic        wait_r;
  wire         t_tk  = t2c_valid && t2c_ready;
  wire         c_tk  = c2t_valid && c2t_ready;
  wire         t_fin = t_tk && t2c_end && !t2c_chain;
  wire         c_fin = c_tk && c2t_end && !c2t_chain;
  // prev_r holds sw1 at the closing byte; more bytes mean data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blk_r  <= 16'h0000;
      msg_r  <= 16'h0000;
      rcnt_r <= 16'h0000;
      ins_r  <= 8'h00;
      prev_r <= 8'h00;
      wait_r <= 1'b0;
    end else begin
      if (t_tk) blk_r <= t2c_end ? 16'h0000 : blk_r + 16'h0001;
      if (t_tk) msg_r <= t_fin ? 16'h0000 : msg_r + 16'h0001;
      if (t_tk && msg_r == ABM_POS_INS) ins_r <= t2c_data;
      if (c_tk) rcnt_r <= c_fin ? 16'h0000 : rcnt_r + 16'h0001;
      if (c_tk) prev_r <= c2t_data;
      if (t_fin) wait_r <= 1'b1;
      else if (c_fin) wait_r <= 1'b0;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_t_stall; t2c_valid && !t2c_ready; endsequence
  sequence s_c_stall; c2t_valid && !c2t_ready; endsequence
  sequence s_c_fin; c_fin; endsequence
  property p_t2c_hold;
    s_t_stall |=> t2c_valid && $stable(t2c_data) && $stable(t2c_end) && $stable(t2c_chain);
  endproperty
  property p_c2t_hold;
    s_c_stall |=> c2t_valid && $stable(c2t_data) && $stable(c2t_end) && $stable(c2t_chain);
  endproperty
  property p_t2c_chain; t2c_valid && t2c_chain |-> t2c_end && blk_r == 16'(IFS - 1); endproperty
  property p_t2c_block; t_tk && blk_r == 16'(IFS - 1) |-> t2c_end; endproperty
  property p_c2t_chain;
    c2t_valid && c2t_chain |-> c2t_end && rcnt_r % 16'(IFS) == 16'(IFS - 1);
  endproperty
  property p_one_cmd; wait_r |-> !t2c_valid; endproperty
  property p_no_orphan; c2t_valid |-> wait_r; endproperty
  property p_sw_data;
    s_c_fin ##0 (rcnt_r > 16'h0001) |-> prev_r == ABM_SW1_NORMAL || prev_r == ABM_SW1_WARN_A
      || prev_r == ABM_SW1_WARN_B || prev_r[7:4] == ABM_SW1_APP_NIB;
  endproperty
  property p_fetch;
    s_c_fin ##0 (ins_r == ABM_INS_FETCH) |-> prev_r == ABM_SW1_PRO
      || (prev_r == ABM_SW_OK[15:8] && c2t_data == ABM_SW_OK[7:0]);
  endproperty
  a_t2c_hold: assert property (p_t2c_hold) else $error("command byte moved while stalled");
  a_c2t_hold: assert property (p_c2t_hold) else $error("response byte moved while stalled");
  a_t2c_chain: assert property (p_t2c_chain) else $error("command chain off block edge");
  a_t2c_block: assert property (p_t2c_block) else $error("command block too long");
  a_c2t_chain: assert property (p_c2t_chain) else $error("response chain without end");
  a_one_cmd: assert property (p_one_cmd) else $error("command before response");
  a_no_orphan: assert property (p_no_orphan) else $error("response without command");
  a_sw_data: assert property (p_sw_data) else $error("data with forbidden status");
  a_fetch: assert property (p_fetch) else $error("fetch closed by wrong status");
endmodule

/* File: tb/test_apdu_block_mapper.sv */
// self-checking bench: both link ends joined
`timescale 1ns/1ps
module test_apdu_block_mapper;
  import abm_pkg::*;
  // ----------
  // signals
  // ----------
  localparam int IFS = 4;
  logic        mclk = 1'b0, rst_n = 1'b0;
  logic [7:0]  t_cd = 8'h00, t_rd, t_pl, c_cd, c_ins, c_rd = 8'h00, c_pl = 8'h00;
  logic        t_cv = 1'b0, t_cl = 1'b0, t_fg = 1'b0, t_crdy, t_rv, t_dn, t_bad, t_err;
  logic        t_ap, t_an, t_pp, t_tb, c_cv, c_cl, c_rrdy, c_hd = 1'b0, c_go = 1'b0;
  logic        c_rv = 1'b0, c_rl = 1'b0, c_pp = 1'b0, c_tb = 1'b0, t_bsy, t_rl;
  logic [15:0] t_sw, c_sw = 16'h0000;
  logic [1:0]  t_case;
  logic [7:0]  cq[$], rq[$];
  logic        cmd_tk = 1'b0, rsp_tk = 1'b0, c_end = 1'b0, t_done = 1'b0, ap, an, rl;
  logic [7:0]  eplen = 8'h00;
  logic [15:0] swt[6] = '{16'h9000, 16'h6110, 16'h6283, 16'h6300, 16'h9F04, 16'h6982};
  int          n_errors = 0, checks = 0, cyc = 0, tno = 0;

  abm_link_if u_abm_link_if ();
  abm_term #(.IFS(IFS)) u_abm_term (.mclk(mclk), .rst_n(rst_n), .link(u_abm_link_if),
    .cmd_data(t_cd), .cmd_valid(t_cv), .cmd_last(t_cl), .cmd_ready(t_crdy), .fetch_go(t_fg),
    .rsp_data(t_rd), .rsp_valid(t_rv), .rsp_last(t_rl), .rsp_done(t_dn), .rsp_sw(t_sw),
    .rsp_bad(t_bad), .xchg_case(t_case), .cmd_err(t_err), .busy(t_bsy), .ack_pos(t_ap),
    .ack_neg(t_an), .pro_pending(t_pp), .pro_len(t_pl), .toolkit_busy(t_tb));
  abm_card #(.IFS(IFS)) u_abm_card (.mclk(mclk), .rst_n(rst_n), .link(u_abm_link_if),
    .cmd_data(c_cd), .cmd_valid(c_cv), .cmd_last(c_cl), .cmd_ins(c_ins), .rsp_go(c_go),
    .rsp_sw(c_sw), .rsp_has_data(c_hd), .rsp_data(c_rd), .rsp_valid(c_rv), .rsp_last(c_rl),
    .rsp_ready(c_rrdy), .pro_pending(c_pp), .pro_len(c_pl), .toolkit_busy(c_tb));
  abm_link_assertions #(.IFS(IFS)) u_abm_link_assertions (.mclk(mclk), .rst_n(rst_n),
    .t2c_data(u_abm_link_if.t2c_data), .t2c_valid(u_abm_link_if.t2c_valid),
    .t2c_ready(u_abm_link_if.t2c_ready), .t2c_end(u_abm_link_if.t2c_end),
    .t2c_chain(u_abm_link_if.t2c_chain), .c2t_data(u_abm_link_if.c2t_data),
    .c2t_valid(u_abm_link_if.c2t_valid), .c2t_ready(u_abm_link_if.c2t_ready),
    .c2t_end(u_abm_link_if.c2t_end), .c2t_chain(u_abm_link_if.c2t_chain));

  initial begin
    forever #2 mclk = ~mclk;
  end
  // ----------
  // monitors and timeout
  // ----------
  // handshakes latched on the edge so drivers never race the flops
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    cmd_tk <= t_cv && t_crdy;
    rsp_tk <= c_rv && c_rrdy;
    if (c_cv) cq.push_back(c_cd);
    if (c_cv && c_cl) c_end <= 1'b1;
    if (t_rv) rq.push_back(t_rd);
    if (t_dn) begin
      t_done <= 1'b1;
      ap <= t_ap;
      an <= t_an;
      rl <= t_rl;
    end
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ----------
  // compare, expectation and verdict
  // ----------
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e, input string m);
    chk_val(16'(g), 16'(e), m);
  endtask
  function automatic bit f_ok(input logic [7:0] s1);
    return s1 == 8'h61 || s1 == 8'h62 || s1 == 8'h63 || s1[7:4] == 4'h9;
  endfunction
  function automatic logic [1:0] f_case(input int n, input int lc);
    return n == 4 ? 2'h0 : n == 5 ? 2'h1 : n == 5 + lc ? 2'h2 : 2'h3;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------
  // one command-response pair
  // ----------
  task automatic run(input logic [7:0] ins, input int lc, input bit le, input logic [15:0] sw,
                     input int nd, input bit pend, input bit tkb, input bit fet);
    logic [7:0]  cmd[$], dq[$], xq[$];
    logic [15:0] fsw;
    logic [1:0]  ecase;
    bit          env, pass;
    int          i;
    env = ins == ABM_INS_ENVELOPE;
    cmd = {ABM_CLA_DEF, ins, 8'($urandom), 8'($urandom)};
    if (fet) cmd = {ABM_CLA_DEF, ABM_INS_FETCH, ABM_P_ZERO, ABM_P_ZERO, eplen};
    if (!fet && lc > 0) cmd.push_back(8'(lc));
    if (!fet) repeat (lc) cmd.push_back(8'($urandom));
    if (!fet && le) cmd.push_back(env ? ABM_ENV_LE : 8'($urandom));
    ecase = f_case(cmd.size(), cmd.size() > 4 ? int'(cmd[4]) : 0);
    cq = {};
    rq = {};
    @(negedge mclk);
    c_end = 1'b0;
    t_done = 1'b0;
    c_pl = 8'($urandom);
    c_pp = pend;
    c_tb = tkb;
    fsw = fet ? ABM_SW_OK : (env && tkb) ? ABM_SW_TK_BUSY : sw;
    if (fsw == ABM_SW_OK && pend) fsw = {ABM_SW1_PRO, c_pl};
    pass = nd > 0 && !(env && tkb) && f_ok(fsw[15:8]);
    repeat (nd) dq.push_back(8'($urandom));
    if (pass) xq = dq;
    xq.push_back(fsw[15:8]);
    xq.push_back(fsw[7:0]);
    t_fg = fet;
    t_cv = !fet;
    t_cd = cmd[0];
    i = fet ? cmd.size() : 0;
    @(negedge mclk);
    t_fg = 1'b0;
    while (i < cmd.size()) begin
      if (cmd_tk) i++;
      t_cv = i < cmd.size();
      t_cd = cmd[i];
      t_cl = i == cmd.size() - 1;
      if (i < cmd.size()) @(negedge mclk);
    end
    while (!c_end) @(negedge mclk);
    chk_flag(t_bsy, 1'b1, "busy in exchange");
    chk_val(16'(cq.size()), 16'(cmd.size()), "card byte count");
    foreach (cmd[k]) chk_val(16'(cq[k]), 16'(cmd[k]), "card byte");
    chk_val(16'(c_ins), 16'(cmd[1]), "card ins");
    c_go = 1'b1;
    c_sw = sw;
    c_hd = nd > 0;
    @(negedge mclk);
    c_go = 1'b0;
    for (int k = 0; pass && k < nd; k++) begin
      c_rv = 1'b1;
      c_rd = dq[k];
      c_rl = k == nd - 1;
      @(negedge mclk);
      while (!rsp_tk) @(negedge mclk);
    end
    c_rv = 1'b0;
    while (!t_done) @(negedge mclk);
    chk_val(16'(rq.size()), 16'(xq.size()), "response length");
    foreach (xq[k]) chk_val(16'(rq[k]), 16'(xq[k]), "response byte");
    chk_val(t_sw, fsw, "status word");
    chk_val(16'(t_case), 16'(ecase), "case");
    chk_flag(t_err, (ins == ABM_INS_TERM_RSP && ecase < 2'h2) || (env && (ecase != 2'h3 ||
             cmd[$] != ABM_ENV_LE)), "command error");
    chk_flag(ap, env && fsw == ABM_SW_OK, "positive ack");
    chk_flag(an, env && (fsw[15:8] == 8'h62 || fsw[15:8] == 8'h63), "negative ack");
    chk_flag(t_bad, 1'b0, "data flag");
    chk_flag(t_pp, fsw[15:8] == ABM_SW1_PRO, "pending");
    if (fsw[15:8] == ABM_SW1_PRO) chk_val(16'(t_pl), 16'(fsw[7:0]), "pending length");
    if (fsw[15:8] == ABM_SW1_PRO) eplen = fsw[7:0];
    if (env) chk_flag(t_tb, fsw == ABM_SW_TK_BUSY, "toolkit busy");
    chk_flag(rl, 1'b1, "last flag");
    chk_flag(t_bsy, 1'b0, "busy after done");
    tno++;
    $display("test %0d ins %h status %h done", tno, ins, fsw);
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    void'($urandom(32'hfe808777));
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    run(8'hA4, 0, 0, 16'h9000, 0, 0, 0, 0);
    run(8'hB0, 0, 1, 16'h6105, 3, 0, 0, 0);
    run(8'hD6, 9, 0, 16'h9000, 0, 1, 0, 0);
    run(ABM_INS_FETCH, 0, 0, 16'h6F00, 7, 0, 0, 1);
    run(ABM_INS_TERM_RSP, 3, 0, 16'h9000, 0, 0, 0, 0);
    run(ABM_INS_TERM_RSP, 0, 0, 16'h9000, 0, 0, 0, 0);
    run(ABM_INS_ENVELOPE, 6, 1, 16'h9000, 5, 0, 0, 0);
    run(ABM_INS_ENVELOPE, 2, 1, 16'h6201, 4, 0, 0, 0);
    run(ABM_INS_ENVELOPE, 3, 1, 16'h6310, 2, 0, 0, 0);
    run(ABM_INS_ENVELOPE, 3, 1, 16'h9000, 4, 0, 1, 0);
    run(ABM_INS_ENVELOPE, 3, 0, 16'h9000, 0, 0, 0, 0);
    run(8'hB2, 0, 1, 16'h6A82, 4, 0, 0, 0);
    run(8'hCA, 0, 1, 16'h9000, 9, 0, 0, 0);
    repeat (8) begin
      run(8'hB0 + 8'($urandom % 8), $urandom % 10, 1'($urandom), swt[$urandom % 6],
          $urandom % 6, 1'($urandom), 1'b0, 1'b0);
    end
    give_verdict();
  end
endmodule
